// ==== rtl/sbst_pkg.sv ====
// constants and state encoding for the memory boundary-scan test port
// Summary of operation
// - inputs taken on test clock rise, outputs change on its fall
// - controller steers the state machine with mode select, sampled on rise
// - undriven mode-select or data-in pin reads as one
// - the current instruction puts exactly one register in the serial path
// - serial data enters the selected register at its top bit
// - serial data leaves from the bottom bit of the selected register
// - five rises with mode select high reach the reset state
// - test port reset leaves memory operation untouched
// - port resets itself at power-up, serial output starts undriven
// - three-bit instruction register, loaded only while in the serial path
// - reset state and power-up load the identification instruction
// - capture-instruction loads the two low bits with pattern 01
// - bypass is one bit and captures zero
// - capture-data samples all pin cells, shift-data puts the chain in path
// - external-test, sample and sample-highz instructions capture the pin ring
// - identification instruction captures and shifts a hardwired 32-bit code
// - a new instruction takes effect only through update-instruction
// - sample-highz holds the read-data bus undriven until next update
// - cell 108 enables the read-data bus under external test
// - output-enable latch is one at power-up and in reset state
package sbst_pkg;
   localparam int IR_W    = 3;
   localparam int ID_W    = 32;
   localparam int BSR_LEN = 109;
   localparam int OE_CELL = 108;

   // instruction codes
   localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] OP_SAMPZ  = 3'h2;
   localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
   localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
   localparam logic [IR_W-1:0] IR_CAPT   = 3'h1;

   localparam logic BYP_CAPT = 1'b0;
   localparam logic OE_RST   = 1'b1;
   localparam logic [BSR_LEN-1:0] LATCH_RST = {1'b1, {(BSR_LEN-1){1'b0}}};

   typedef enum logic [15:0] {
      ST_RESET = 16'h0001,
      ST_IDLE  = 16'h0002,
      ST_SELDR = 16'h0004,
      ST_CAPDR = 16'h0008,
      ST_SHDR  = 16'h0010,
      ST_EX1DR = 16'h0020,
      ST_PAUDR = 16'h0040,
      ST_EX2DR = 16'h0080,
      ST_UPDR  = 16'h0100,
      ST_SELIR = 16'h0200,
      ST_CAPIR = 16'h0400,
      ST_SHIR  = 16'h0800,
      ST_EX1IR = 16'h1000,
      ST_PAUIR = 16'h2000,
      ST_EX2IR = 16'h4000,
      ST_UPIR  = 16'h8000
   } sbst_state_t;
endpackage : sbst_pkg

// ==== rtl/sbst_tap.sv ====
// boundary-scan test port: controller, scan registers and bus-enable crossing
`timescale 1ns/1ps
module sbst_tap #(
   parameter logic [sbst_pkg::ID_W-1:0] ID_VALUE = 32'h1234_5001 // arbitrary value
) (
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire logic                         tckClk,
   input  wire logic                         tmsIn,
   input  wire logic                         tmsDrv,
   input  wire logic                         tdiIn,
   input  wire logic                         tdiDrv,
   output logic                              tdoOut,
   output logic                              tdoOe,
   input  wire logic [sbst_pkg::BSR_LEN-1:0] ringPins,
   output logic      [sbst_pkg::BSR_LEN-1:0] ringDrive,
   output logic                              extestOn,
   input  wire logic                         memQEn,
   output logic                              memQOe
);
   import sbst_pkg::*;

   sbst_state_t                state_r;
   sbst_state_t                state_nxt;
   logic                       rqS1_r;
   logic                       rqS2_r;
   logic                       rstReq_r;
   logic                       ackS1_r;
   logic                       ackS2_r;
   logic                       live_r;
   logic                       hzS1_r;
   logic                       hzS2_r;
   logic                       qOe_r;
   logic                       tmsEff;
   logic                       tdiEff;
   logic [IR_W-1:0]            irShift_r;
   logic [IR_W-1:0]            ir_r;
   logic                       byp_r;
   logic [ID_W-1:0]            idShift_r;
   logic [BSR_LEN-1:0]         bsrShift_r;
   logic [BSR_LEN-1:0]         latch_r;
   logic [BSR_LEN-1:0]         ringS1_r;
   logic [BSR_LEN-1:0]         ringS2_r;
   logic                       tdo_r;
   logic                       tdoOe_r;
   logic                       qOff_r;
   logic                       tdoBit;
   logic                       selBsr;
   logic                       selId;

   // ---------------- ref_clk side ----------------

   // reset request held until the test side acknowledges it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rstReq_r <= 1'b1;
      end else if (ackS2_r) begin
         rstReq_r <= 1'b0;
      end
   end

   // acknowledge comes back through two flops
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ackS1_r <= 1'b0;
         ackS2_r <= 1'b0;
      end else begin
         ackS1_r <= rqS2_r;
         ackS2_r <= ackS1_r;
      end
   end

   // serial output stays undriven until the port has really reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         live_r <= 1'b0;
      end else if (ackS2_r) begin
         live_r <= 1'b1;
      end
   end

   // bus-off level from the test side, double flopped
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hzS1_r <= 1'b0;
         hzS2_r <= 1'b0;
      end else begin
         hzS1_r <= qOff_r;
         hzS2_r <= hzS1_r;
      end
   end

   // memory keeps its own enable; the test port only forces it off
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         qOe_r <= 1'b0;
      end else begin
         qOe_r <= memQEn & ~hzS2_r;
      end
   end

   assign memQOe = qOe_r;
   assign tdoOe  = tdoOe_r & live_r;
   assign tdoOut = tdo_r;

   // ---------------- test clock side ----------------

   // unconnected pins float high through the pull-up
   assign tmsEff = tmsDrv ? tmsIn : 1'b1;
   assign tdiEff = tdiDrv ? tdiIn : 1'b1;

   // reset request brought into the test clock domain
   always_ff @(posedge tckClk) begin
      rqS1_r <= rstReq_r;
      rqS2_r <= rqS1_r;
   end

   // pin ring passes two flops; values caught mid-edge carry no guarantee
   always_ff @(posedge tckClk) begin
      ringS1_r <= ringPins;
      ringS2_r <= ringS1_r;
   end

   // controller next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: state_nxt = tmsEff ? ST_RESET : ST_IDLE;
         ST_IDLE:  state_nxt = tmsEff ? ST_SELDR : ST_IDLE;
         ST_SELDR: state_nxt = tmsEff ? ST_SELIR : ST_CAPDR;
         ST_CAPDR: state_nxt = tmsEff ? ST_EX1DR : ST_SHDR;
         ST_SHDR:  state_nxt = tmsEff ? ST_EX1DR : ST_SHDR;
         ST_EX1DR: state_nxt = tmsEff ? ST_UPDR  : ST_PAUDR;
         ST_PAUDR: state_nxt = tmsEff ? ST_EX2DR : ST_PAUDR;
         ST_EX2DR: state_nxt = tmsEff ? ST_UPDR  : ST_SHDR;
         ST_UPDR:  state_nxt = tmsEff ? ST_SELDR : ST_IDLE;
         ST_SELIR: state_nxt = tmsEff ? ST_RESET : ST_CAPIR;
         ST_CAPIR: state_nxt = tmsEff ? ST_EX1IR : ST_SHIR;
         ST_SHIR:  state_nxt = tmsEff ? ST_EX1IR : ST_SHIR;
         ST_EX1IR: state_nxt = tmsEff ? ST_UPIR  : ST_PAUIR;
         ST_PAUIR: state_nxt = tmsEff ? ST_EX2IR : ST_PAUIR;
         ST_EX2IR: state_nxt = tmsEff ? ST_UPIR  : ST_SHIR;
         ST_UPIR:  state_nxt = tmsEff ? ST_SELDR : ST_IDLE;
         default:  state_nxt = ST_RESET;
      endcase
   end

   // controller state, mode select taken on the rising edge
   always_ff @(posedge tckClk) begin
      if (rqS2_r) begin
         state_r <= ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // instruction shift stage
   always_ff @(posedge tckClk) begin
      if (state_r == ST_CAPIR) begin
         irShift_r <= IR_CAPT;
      end else if (state_r == ST_SHIR) begin
         irShift_r <= {tdiEff, irShift_r[IR_W-1:1]};
      end
   end

   // which data register the current instruction selects
   assign selBsr = (ir_r == OP_EXTEST) || (ir_r == OP_SAMPLE) || (ir_r == OP_SAMPZ);
   assign selId  = (ir_r == OP_IDCODE);

   // bypass bit; reserved codes fall back onto it
   always_ff @(posedge tckClk) begin
      if (!selBsr && !selId && state_r == ST_CAPDR) begin
         byp_r <= BYP_CAPT;
      end else if (!selBsr && !selId && state_r == ST_SHDR) begin
         byp_r <= tdiEff;
      end
   end

   // identification register
   always_ff @(posedge tckClk) begin
      if (selId && state_r == ST_CAPDR) begin
         idShift_r <= ID_VALUE;
      end else if (selId && state_r == ST_SHDR) begin
         idShift_r <= {tdiEff, idShift_r[ID_W-1:1]};
      end
   end

   // boundary chain over the pin ring
   always_ff @(posedge tckClk) begin
      if (selBsr && state_r == ST_CAPDR) begin
         bsrShift_r <= ringS2_r;
      end else if (selBsr && state_r == ST_SHDR) begin
         bsrShift_r <= {tdiEff, bsrShift_r[BSR_LEN-1:1]};
      end
   end

   // serial output mux: one register at a time
   always_comb begin
      tdoBit = byp_r;
      if (state_r == ST_SHIR) begin
         tdoBit = irShift_r[0];
      end else if (selBsr) begin
         tdoBit = bsrShift_r[0];
      end else if (selId) begin
         tdoBit = idShift_r[0];
      end
   end

   // serial output and its enable change on the falling edge
   always_ff @(negedge tckClk) begin
      if (rqS2_r) begin
         tdo_r   <= 1'b0;
         tdoOe_r <= 1'b0;
      end else begin
         tdo_r   <= tdoBit;
         tdoOe_r <= (state_r == ST_SHIR) || (state_r == ST_SHDR);
      end
   end

   // current instruction updated in update-instruction, preset to identification in reset
   always_ff @(negedge tckClk) begin
      if (rqS2_r || state_r == ST_RESET) begin
         ir_r <= OP_IDCODE;
      end else if (state_r == ST_UPIR) begin
         ir_r <= irShift_r;
      end
   end

   // parallel latches of the boundary chain
   always_ff @(negedge tckClk) begin
      if (rqS2_r || state_r == ST_RESET) begin
         latch_r <= LATCH_RST;
      end else if (selBsr && state_r == ST_UPDR) begin
         latch_r <= bsrShift_r;
      end
   end

   // bus-off level: sample-highz, or external test with enable cell low
   always_ff @(negedge tckClk) begin
      if (rqS2_r) begin
         qOff_r <= 1'b0;
      end else begin
         qOff_r <= (ir_r == OP_SAMPZ) || ((ir_r == OP_EXTEST) && !latch_r[OE_CELL]);
      end
   end

   assign ringDrive = latch_r;
   assign extestOn  = (ir_r == OP_EXTEST);

   // ---------------- checks on the test clock ----------------

   // every check sleeps while the power-up request is still open
   five_high_a: assert property (@(posedge tckClk) disable iff (rqS2_r)
      tmsEff [*5] |=> (state_r == ST_RESET))
      else $error("five high mode-select edges did not reach reset");

   irq_capture_a: assert property (@(posedge tckClk) disable iff (rqS2_r)
      (state_r == ST_CAPIR) |=> (irShift_r[1:0] == IR_CAPT[1:0]))
      else $error("instruction capture pattern wrong");

   ir_update_a: assert property (@(negedge tckClk) disable iff (rqS2_r)
      (state_r != ST_UPIR && state_r != ST_RESET) |=> $stable(ir_r))
      else $error("instruction changed outside update");

   ir_reset_a: assert property (@(negedge tckClk) disable iff (rqS2_r)
      (state_r == ST_RESET) |=> (ir_r == OP_IDCODE))
      else $error("reset state did not load identification");

   tdo_drive_a: assert property (@(negedge tckClk) disable iff (rqS2_r)
      (state_r != ST_SHIR && state_r != ST_SHDR) |=> !tdoOe_r)
      else $error("serial output enable outside shift states");

   tdo_lsb_a: assert property (@(negedge tckClk) disable iff (rqS2_r)
      (state_r == ST_SHDR && selId) |=> (tdo_r == $past(idShift_r[0])))
      else $error("serial output not from bottom bit");

   id_capture_a: assert property (@(posedge tckClk) disable iff (rqS2_r)
      (state_r == ST_CAPDR && selId) |=> (idShift_r == ID_VALUE))
      else $error("identification code not captured");

   byp_capture_a: assert property (@(posedge tckClk) disable iff (rqS2_r)
      (state_r == ST_CAPDR && !selId && !selBsr) |=> (byp_r == BYP_CAPT))
      else $error("bypass did not capture zero");

   bsr_shift_a: assert property (@(posedge tckClk) disable iff (rqS2_r)
      (state_r == ST_SHDR && selBsr) |=> (bsrShift_r[BSR_LEN-1] == $past(tdiEff)))
      else $error("chain top bit not taken from data-in");

   oe_reset_a: assert property (@(negedge tckClk) disable iff (rqS2_r)
      (state_r == ST_RESET) |=> (latch_r[OE_CELL] == OE_RST))
      else $error("enable latch not preset in reset");

   oe_latch_a: assert property (@(negedge tckClk) disable iff (rqS2_r)
      (state_r != ST_UPDR && state_r != ST_RESET) |=> $stable(latch_r[OE_CELL]))
      else $error("enable latch moved outside update-data");

   hiz_level_a: assert property (@(negedge tckClk) disable iff (rqS2_r)
      (ir_r == OP_SAMPZ) |=> qOff_r)
      else $error("sample-highz did not turn bus off");

endmodule : sbst_tap

// ==== testbench/sbst_ctl_model.sv ====
// board-side controller model that drives the test port's serial pins
`timescale 1ns/1ps
module sbst_ctl_model (
   output logic      tckClk,
   output logic      tmsIn,
   output logic      tmsDrv,
   output logic      tdiIn,
   output logic      tdiDrv,
   input  wire logic tdoOut,
   input  wire logic tdoOe
);
   logic [127:0] lastOut;
   int           lowGap;
   event         scanDone;

   // clock parked low between frames, both lines released
   initial begin
      tckClk  = 1'b0;
      tmsIn   = 1'b0;
      tmsDrv  = 1'b0;
      tdiIn   = 1'b0;
      tdiDrv  = 1'b0;
      lowGap  = 0;
      lastOut = '0;
   end

   // one tck period; a released line toggles so stale levels never pass
   task automatic step(input logic tms, input logic drvTms, input logic tdi,
                       input logic drvTdi, output logic tdo, output logic oe);
      tmsDrv = drvTms;
      tmsIn  = drvTms ? tms : ~tmsIn;
      tdiDrv = drvTdi;
      tdiIn  = drvTdi ? tdi : ~tdiIn;
      #(6 + lowGap);
      tckClk = 1'b1;
      tdo    = tdoOut;
      oe     = tdoOe;
      #6;
      tckClk = 1'b0;
   endtask : step

   // mode select left floating, so the pull-up walks the port to reset
   task automatic float_reset(input int n);
      logic d;
      logic e;
      for (int i = 0; i < n; i++) step(1'b1, 1'b0, 1'b0, 1'b0, d, e);
   endtask : float_reset

   // idle to idle scan; bit 127 of the result says the output stayed driven
   // instruction scans only ever hand in four of the five defined codes here, never identification
   task automatic scan(input logic isIr, input int len, input logic [127:0] din,
                       input logic drvTdi);
      logic [127:0] dout;
      logic         oe;
      logic         oeAll;
      logic         t;
      dout  = '0;
      oeAll = 1'b1;
      repeat (2) step(1'b0, 1'b1, 1'b0, 1'b0, t, oe);
      step(1'b1, 1'b1, 1'b0, 1'b0, t, oe);
      if (isIr) step(1'b1, 1'b1, 1'b0, 1'b0, t, oe);
      repeat (2) step(1'b0, 1'b1, 1'b0, 1'b0, t, oe);
      for (int i = 0; i < len; i++) begin
         step(i == len - 1, 1'b1, din[i], drvTdi, dout[i], oe);
         oeAll &= oe;
      end
      step(1'b1, 1'b1, 1'b0, 1'b0, t, oe);
      step(1'b0, 1'b1, 1'b0, 1'b0, t, oe);
      lastOut = {oeAll, dout[126:0]};
      -> scanDone;
   endtask : scan
endmodule : sbst_ctl_model

// ==== testbench/testbench.sv ====
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module testbench;
   import sbst_pkg::*;
   localparam logic [ID_W-1:0] TB_ID = 32'h5a3c_0f01; // arbitrary value
   logic               ref_clk;
   logic               rst;
   logic               tckClk;
   logic               tmsIn;
   logic               tmsDrv;
   logic               tdiIn;
   logic               tdiDrv;
   logic               tdoOut;
   logic               tdoOe;
   logic [BSR_LEN-1:0] ringPins;
   logic [BSR_LEN-1:0] ringDrive;
   logic               extestOn;
   logic               memQEn;
   logic               memQOe;
   logic [127:0]       expQ[$];
   logic [127:0]       rnd;
   logic [BSR_LEN-1:0] pat;
   logic               off;
   logic [IR_W-1:0]    ops[4];
   int                 errCount;
   int                 samplesChecked;

   sbst_tap #(.ID_VALUE(TB_ID)) dut (.ref_clk(ref_clk), .rst(rst), .tckClk(tckClk),
      .tmsIn(tmsIn), .tmsDrv(tmsDrv), .tdiIn(tdiIn), .tdiDrv(tdiDrv), .tdoOut(tdoOut),
      .tdoOe(tdoOe), .ringPins(ringPins), .ringDrive(ringDrive), .extestOn(extestOn),
      .memQEn(memQEn), .memQOe(memQOe));

   sbst_ctl_model ctl (.tckClk(tckClk), .tmsIn(tmsIn), .tmsDrv(tmsDrv), .tdiIn(tdiIn),
      .tdiDrv(tdiDrv), .tdoOut(tdoOut), .tdoOe(tdoOe));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic check_lvl(input string name, input logic [BSR_LEN-1:0] exp,
                            input logic [BSR_LEN-1:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check_lvl

   task automatic check_scan(input logic [127:0] exp, input logic [127:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR scan expected %h seen %h", exp, got);
      end
   endtask : check_scan

   // top bit of a note demands the output enable held through the shift
   task automatic note(input logic [127:0] v);
      expQ.push_back({1'b1, v[126:0]});
   endtask : note

   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : giveVerdict

   // oldest note against each finished scan
   initial forever begin
      @(ctl.scanDone);
      if (expQ.size() == 0) begin
         errCount++;
         $display("ERROR scan expected none seen %h", ctl.lastOut);
      end else begin
         check_scan(expQ.pop_front(), ctl.lastOut);
      end
   end

   // hang guard
   initial begin
      repeat (60000) @(posedge ref_clk);
      errCount++;
      $display("ERROR watchdog expected finish seen hang");
      giveVerdict();
   end

   initial begin
      rst = 1'b1;
      memQEn = 1'b0;
      ringPins = '0;
      errCount = 0;
      samplesChecked = 0;
      ops = '{OP_EXTEST, OP_SAMPLE, OP_EXTEST, OP_SAMPZ};
      void'($urandom(32'h73088540));
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      memQEn = 1'b1;
      ctl.float_reset(8);
      repeat (10) @(negedge ref_clk);
      check_lvl("tdoOe", '0, BSR_LEN'(tdoOe));
      check_lvl("memQOe", BSR_LEN'(1'b1), BSR_LEN'(memQOe));
      check_lvl("ringDrive", LATCH_RST, ringDrive);
      // two more rises drain the power-up request, else the first scan is eaten
      ctl.float_reset(2);
      $display("test reset done");
      rnd = {$urandom, $urandom, $urandom, $urandom};
      note(128'(TB_ID));
      ctl.scan(1'b0, ID_W, rnd, 1'b1);
      @(negedge ref_clk);
      check_lvl("tdoOe", '0, BSR_LEN'(tdoOe));
      note(128'(IR_CAPT));
      ctl.scan(1'b1, IR_W, 128'(OP_BYPASS), 1'b1);
      note(128'({rnd[6:0], BYP_CAPT}));
      ctl.scan(1'b0, 8, rnd, 1'b1);
      ctl.lowGap = 40;
      note(128'({7'h7f, BYP_CAPT}));
      ctl.scan(1'b0, 8, '0, 1'b0);
      ctl.lowGap = 0;
      $display("test id and bypass done");
      foreach (ops[i]) begin
         note(128'(IR_CAPT));
         ctl.scan(1'b1, IR_W, 128'(ops[i]), 1'b1);
         @(negedge ref_clk);
         rnd = {$urandom, $urandom, $urandom, $urandom};
         ringPins = rnd[BSR_LEN-1:0];
         memQEn = rnd[127];
         rnd = {$urandom, $urandom, $urandom, $urandom};
         pat = rnd[BSR_LEN-1:0];
         pat[OE_CELL] = i[1];
         note(128'(ringPins));
         ctl.scan(1'b0, BSR_LEN, 128'(pat), 1'b1);
         off = (ops[i] == OP_SAMPZ) || (ops[i] == OP_EXTEST && !pat[OE_CELL]);
         repeat (6) @(negedge ref_clk);
         check_lvl("ringDrive", pat, ringDrive);
         check_lvl("extestOn", BSR_LEN'(ops[i] == OP_EXTEST), BSR_LEN'(extestOn));
         check_lvl("memQOe", BSR_LEN'(memQEn & !off), BSR_LEN'(memQOe));
         $display("test boundary op %0d done", ops[i]);
      end
      memQEn = 1'b1;
      ctl.float_reset(5);
      repeat (6) @(negedge ref_clk);
      check_lvl("ringDrive", LATCH_RST, ringDrive);
      check_lvl("memQOe", BSR_LEN'(1'b1), BSR_LEN'(memQOe));
      note(128'(TB_ID));
      ctl.scan(1'b0, ID_W, '0, 1'b1);
      $display("test port reset done");
      for (int k = 0; k < 100 && expQ.size() != 0; k++) @(negedge ref_clk);
      if (expQ.size() != 0) begin
         errCount++;
         $display("ERROR scan expected result seen none");
      end
      giveVerdict();
   end
endmodule : testbench
